// File: logic/standby_pkg.sv
package standby_pkg;

   // Standby modes of the controller.
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HALT = 2'b01,
      ST_STOP = 2'b10,
      ST_SETTLE = 2'b11
   } mode_t;

   // Resume action reported to the core.
   typedef enum logic [1:0] {
      WAKE_NONE = 2'b00,
      WAKE_NEXT = 2'b01,
      WAKE_SERVICE = 2'b10,
      WAKE_RESET = 2'b11
   } wake_t;

   // Peripheral run enables during standby.
   typedef struct packed {
      logic inv_timer;
      logic updown_cnt;
      logic timer16;
      logic buzzer;
      logic adc;
      logic muldiv;
      logic timer_a;
      logic timer_b;
      logic timer_h;
      logic async_serial_channel;
      logic clocked_serial_channel;
      logic rto;
      logic wdt;
      logic always_on;
   } periph_en_t;

   // APB register byte offsets.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // Field positions in the config register.
   localparam int CFG_OSC_SETTLE_TIME_SELECT_LSB = 0;
   localparam int CFG_TA_EXT = 3;
   localparam int CFG_TB_EXT = 4;
   localparam int CFG_TH_FROM_A = 5;
   localparam int CFG_UART_FROM_A = 6;
   localparam int CFG_CSI_EXT = 7;
   localparam int CFG_RTO_TB = 8;
   localparam int CFG_RTO_EXT = 9;
   localparam int CFG_OSC_LOCKED = 10;

   // Reset values.
   localparam logic [10:0] CFG_RESET = 11'h405;
   localparam logic [2:0] OSC_SETTLE_TIME_SELECT_RESET = 3'h5;

   // Settle counts per select code, in clock cycles.
   localparam int SETTLE_BASE_LOG2 = 4;

endpackage : standby_pkg

// File: logic/standby_halt_stop_control.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module standby_halt_stop_control #(
   parameter int N_IRQ = 8
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ext_reset_n,
   input wire logic i_halt_instr,
   input wire logic i_stop_instr,
   input wire logic [N_IRQ-1:0] i_irq_flag,
   input wire logic [N_IRQ-1:0] i_irq_mask_flag,
   input wire logic [N_IRQ-1:0] i_irq_priority_flag,
   input wire logic i_nmi,
   input wire logic i_global_irq_enable,
   input wire logic i_in_service_priority_flag,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_cpu_clk_en,
   output logic o_port_hold,
   output logic o_core_reset,
   output logic [1:0] o_wake_action,
   output logic o_wake_pulse,
   output standby_pkg::periph_en_t o_periph_en
);

   // The request vectors are reduced with plain OR trees, so a zero-wide vector cannot be served.
   if (N_IRQ < 1 || N_IRQ > 32) begin : g_bad_width
      $error("N_IRQ must be 1 to 32");
   end

   // Pin-side reset goes through two flops before use.
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= 1'b1;
      end else begin
         rst_meta_ff <= i_ext_reset_n;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   logic ext_rst;
   assign ext_rst = !rst_sync_ff;

   // Wake qualification: any pending unmasked flag wakes the core.
   logic [N_IRQ-1:0] pend;
   logic wake_req;
   logic hi_pend;
   logic svc_ok;
   always_comb begin
      pend = i_irq_flag & ~i_irq_mask_flag;
      wake_req = |pend;
      hi_pend = |(pend & ~i_irq_priority_flag);
      // High priority needs only the enable; low priority needs the in-service flag too.
      svc_ok = i_global_irq_enable && (hi_pend || i_in_service_priority_flag);
   end

   // Register file: control pulse, config, status.
   logic [10:0] cfg_ff;
   logic [10:0] nxt_cfg;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;
   logic sw_stop;
   logic setup;
   logic commit;
   standby_pkg::mode_t mode_ff;
   standby_pkg::mode_t nxt_mode;
   standby_pkg::wake_t pend_act_ff;
   standby_pkg::wake_t nxt_pend_act;

   // One wait state: the answer comes the cycle after the access phase starts. Writes land only at
   // the edge where the master sees pready high, so an access abandoned early changes nothing.
   always_comb begin
      setup = i_psel && i_penable && !pready_ff;
      commit = i_psel && i_penable && pready_ff && i_pwrite;
      nxt_cfg = cfg_ff;
      nxt_prdata = prdata_ff;
      nxt_pready = setup;
      nxt_pslverr = 1'b0;
      sw_stop = commit && (i_paddr == standby_pkg::ADDR_CTRL) && i_pwdata[0];
      if (commit && (i_paddr == standby_pkg::ADDR_CFG)) begin
         nxt_cfg = i_pwdata[10:0];
      end
      if (setup) begin
         unique case (i_paddr)
            standby_pkg::ADDR_CTRL: begin
               nxt_prdata = 32'h0000_0000;
            end
            standby_pkg::ADDR_CFG: begin
               nxt_prdata = {21'h000000, cfg_ff};
            end
            standby_pkg::ADDR_STATUS: begin
               nxt_prdata = {28'h0000000, pend_act_ff, mode_ff};
            end
            default: begin
               nxt_prdata = 32'h0000_0000;
               nxt_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_ff <= standby_pkg::CFG_RESET;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         cfg_ff <= nxt_cfg;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Settle length doubles per select step, from 16 up to 2048 cycles.
   logic [11:0] settle_len;
   always_comb begin
      settle_len = 12'(1 << (standby_pkg::SETTLE_BASE_LOG2 + int'(cfg_ff[2:0])));
   end

   // Standby sequencer.
   logic [11:0] cnt_ff;
   logic [11:0] nxt_cnt;
   logic wake_ff;
   logic nxt_wake;
   logic [1:0] act_ff;
   logic [1:0] nxt_act;
   logic core_rst_ff;
   logic nxt_core_rst;
   logic stop_go;
   always_comb begin
      stop_go = i_stop_instr || sw_stop;
      nxt_mode = mode_ff;
      nxt_cnt = cnt_ff;
      nxt_pend_act = pend_act_ff;
      nxt_wake = 1'b0;
      nxt_act = act_ff;
      nxt_core_rst = ext_rst;
      unique case (mode_ff)
         standby_pkg::ST_RUN: begin
            if (stop_go && !ext_rst) begin
               if (wake_req || i_nmi) begin
                  // Pending request: fall back to HALT-like settle wait.
                  nxt_mode = standby_pkg::ST_SETTLE;
                  nxt_cnt = settle_len;
                  nxt_pend_act = (i_nmi || svc_ok) ? standby_pkg::WAKE_SERVICE : standby_pkg::WAKE_NEXT;
               end else begin
                  nxt_mode = standby_pkg::ST_STOP;
               end
            end else if (i_halt_instr && !ext_rst) begin
               nxt_mode = standby_pkg::ST_HALT;
            end
         end
         standby_pkg::ST_HALT: begin
            if (ext_rst) begin
               nxt_mode = standby_pkg::ST_RUN;
               nxt_wake = 1'b1;
               nxt_act = standby_pkg::WAKE_RESET;
            end else if (i_nmi || wake_req) begin
               nxt_mode = standby_pkg::ST_RUN;
               nxt_wake = 1'b1;
               nxt_act = (i_nmi || svc_ok) ? standby_pkg::WAKE_SERVICE : standby_pkg::WAKE_NEXT;
            end
         end
         standby_pkg::ST_STOP: begin
            // Reset holds the core while the oscillator settles.
            if (ext_rst) begin
               nxt_mode = standby_pkg::ST_SETTLE;
               nxt_cnt = settle_len;
               nxt_pend_act = standby_pkg::WAKE_RESET;
            end else if (i_nmi) begin
               nxt_mode = standby_pkg::ST_SETTLE;
               nxt_cnt = settle_len;
               nxt_pend_act = standby_pkg::WAKE_SERVICE;
            end else if (wake_req) begin
               nxt_mode = standby_pkg::ST_SETTLE;
               nxt_cnt = settle_len;
               nxt_pend_act = svc_ok ? standby_pkg::WAKE_SERVICE : standby_pkg::WAKE_NEXT;
            end
         end
         standby_pkg::ST_SETTLE: begin
            nxt_core_rst = ext_rst || (pend_act_ff == standby_pkg::WAKE_RESET);
            if (cnt_ff <= 12'h001) begin
               nxt_mode = standby_pkg::ST_RUN;
               nxt_cnt = 12'h000;
               nxt_wake = 1'b1;
               nxt_act = pend_act_ff;
               nxt_pend_act = standby_pkg::WAKE_NONE;
            end else begin
               nxt_cnt = cnt_ff - 12'h001;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_ff <= standby_pkg::ST_RUN;
         cnt_ff <= 12'h000;
         pend_act_ff <= standby_pkg::WAKE_NONE;
         wake_ff <= 1'b0;
         act_ff <= standby_pkg::WAKE_NONE;
         core_rst_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         cnt_ff <= nxt_cnt;
         pend_act_ff <= nxt_pend_act;
         wake_ff <= nxt_wake;
         act_ff <= nxt_act;
         core_rst_ff <= nxt_core_rst;
      end
   end

   // Peripheral gating. In STOP only externally clocked paths, the always-on block and, with CFG_OSC_LOCKED set, the watchdog keep running.
   standby_pkg::periph_en_t pen;
   standby_pkg::periph_en_t pen_ff;
   logic in_stop;
   logic ta_run;
   logic tb_run;
   always_comb begin
      in_stop = (mode_ff == standby_pkg::ST_STOP);
      ta_run = !in_stop || cfg_ff[standby_pkg::CFG_TA_EXT];
      tb_run = !in_stop || cfg_ff[standby_pkg::CFG_TB_EXT];
      pen.inv_timer = !in_stop;
      pen.updown_cnt = !in_stop;
      pen.timer16 = !in_stop;
      pen.buzzer = !in_stop;
      pen.adc = !in_stop;
      pen.muldiv = !in_stop;
      pen.always_on = 1'b1;
      pen.timer_a = ta_run;
      pen.timer_b = tb_run;
      pen.timer_h = !in_stop || (cfg_ff[standby_pkg::CFG_TH_FROM_A] && ta_run);
      pen.async_serial_channel = !in_stop || (cfg_ff[standby_pkg::CFG_UART_FROM_A] && ta_run);
      pen.clocked_serial_channel = !in_stop || cfg_ff[standby_pkg::CFG_CSI_EXT];
      pen.rto = !in_stop || (cfg_ff[standby_pkg::CFG_RTO_TB] && tb_run)
         || cfg_ff[standby_pkg::CFG_RTO_EXT];
      pen.wdt = !in_stop || cfg_ff[standby_pkg::CFG_OSC_LOCKED];
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pen_ff <= '1;
      end else begin
         pen_ff <= pen;
      end
   end

   // Port hold and core clock enable follow the next mode, so they line up with the mode register.
   logic in_stop_ff;
   logic cpu_en_ff;
   logic nxt_hold;
   logic nxt_cpu_en;
   always_comb begin
      nxt_hold = (nxt_mode == standby_pkg::ST_STOP);
      nxt_cpu_en = (nxt_mode == standby_pkg::ST_RUN);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_stop_ff <= 1'b0;
         cpu_en_ff <= 1'b1;
      end else begin
         in_stop_ff <= nxt_hold;
         cpu_en_ff <= nxt_cpu_en;
      end
   end

   // Outputs, all from flops.
   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_cpu_clk_en = cpu_en_ff;
   assign o_port_hold = in_stop_ff;
   assign o_core_reset = core_rst_ff;
   assign o_wake_action = act_ff;
   assign o_wake_pulse = wake_ff;
   assign o_periph_en = pen_ff;

   property p_stop_entry;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode_ff == standby_pkg::ST_RUN && i_stop_instr && !ext_rst && !wake_req && !i_nmi)
         |=> (mode_ff == standby_pkg::ST_STOP);
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

   property p_pending_settle;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode_ff == standby_pkg::ST_RUN && i_stop_instr && !ext_rst && wake_req)
         |=> (mode_ff == standby_pkg::ST_SETTLE);
   endproperty
   a_pending_settle: assert property (p_pending_settle) else $error("pending stop not settling");

   property p_masked_hold;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode_ff == standby_pkg::ST_STOP && !wake_req && !i_nmi && !ext_rst) |=> (mode_ff == standby_pkg::ST_STOP);
   endproperty
   a_masked_hold: assert property (p_masked_hold) else $error("stop left without source");

   property p_nmi_service;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode_ff == standby_pkg::ST_STOP && i_nmi && !ext_rst)
         |=> (pend_act_ff == standby_pkg::WAKE_SERVICE);
   endproperty
   a_nmi_service: assert property (p_nmi_service) else $error("nmi not serviced");

   property p_halt_reset;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode_ff == standby_pkg::ST_HALT && ext_rst) |=> (o_wake_action == standby_pkg::WAKE_RESET && o_wake_pulse);
   endproperty
   a_halt_reset: assert property (p_halt_reset) else $error("halt reset missed");

   property p_halt_next;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode_ff == standby_pkg::ST_HALT && !ext_rst && !i_nmi && wake_req && !i_global_irq_enable)
         |=> (o_wake_action == standby_pkg::WAKE_NEXT);
   endproperty
   a_halt_next: assert property (p_halt_next) else $error("disabled wake not next");

   property p_wdt_gate;
      @(posedge i_clk) disable iff (!i_arst_n)
      (in_stop && !cfg_ff[standby_pkg::CFG_OSC_LOCKED]) |=> !o_periph_en.wdt;
   endproperty
   a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog ran in stop");

   property p_adc_gate;
      @(posedge i_clk) disable iff (!i_arst_n)
      in_stop |=> (!o_periph_en.adc && o_periph_en.always_on);
   endproperty
   a_adc_gate: assert property (p_adc_gate) else $error("fixed peripheral ran in stop");

endmodule : standby_halt_stop_control

// File: bench/core_model.sv
`timescale 1ns/1ps
// Interrupt controller side of the core: request flags stay set until a serviced wake or i_clear clears them.
module core_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [7:0] i_raise,
   input wire logic [7:0] i_clear,
   input wire logic i_wake_pulse,
   input wire logic [1:0] i_wake_action,
   output logic [7:0] o_irq_flag
);
   logic [7:0] nxt_flag;
   logic [7:0] flag_ff;

   // A serviced wake acknowledges the flags; a plain resume leaves them pending for software.
   always_comb begin
      nxt_flag = (flag_ff | i_raise) & ~i_clear;
      if (i_wake_pulse && i_wake_action == 2'h2) begin
         nxt_flag = 8'h00;
      end
   end

   // Flags are registered so that they reach the controller on the edge after a raise.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_ff <= 8'h00;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign o_irq_flag = flag_ff;
endmodule : core_model

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb;
   logic clk, rst_n, ext_n, halt, stop, nmi, ie, in_service_priority_flag, psel, penable, pwrite, pready, pslverr;
   logic cpu_en, hold, creset, wpulse, err;
   logic [7:0] paddr, mask, prio, raise, clr, flag;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] wact;
   logic [5:0] c;
   logic [5:0] tbl [6] = '{6'h01, 6'h0A, 6'h15, 6'h19, 6'h1E, 6'h2C};
   standby_pkg::periph_en_t pen;
   int n_fail, total_checks, n;

   standby_halt_stop_control #(.N_IRQ(8)) dut_u (.i_clk(clk), .i_arst_n(rst_n), .i_ext_reset_n(ext_n),
      .i_halt_instr(halt), .i_stop_instr(stop), .i_irq_flag(flag), .i_irq_mask_flag(mask),
      .i_irq_priority_flag(prio), .i_nmi(nmi), .i_global_irq_enable(ie), .i_in_service_priority_flag(in_service_priority_flag),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_cpu_clk_en(cpu_en), .o_port_hold(hold),
      .o_core_reset(creset), .o_wake_action(wact), .o_wake_pulse(wpulse), .o_periph_en(pen));
   core_model core_u (.i_clk(clk), .i_arst_n(rst_n), .i_raise(raise), .i_clear(clr), .i_wake_pulse(wpulse),
      .i_wake_action(wact), .o_irq_flag(flag));

   // Free-running 100 ns clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick

   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse_instr(input logic is_stop);
      if (is_stop) stop <= 1'b1; else halt <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      halt <= 1'b0;
   endtask : pulse_instr

   task automatic set_raise(input logic [7:0] v);
      raise <= v;
      @(posedge clk);
      raise <= 8'h00;
   endtask : set_raise

   // Waits a bounded number of cycles; wpulse stays low afterwards if no wake came.
   task automatic wait_pulse(input int lim);
      n = 0;
      while (wpulse !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_pulse

   task automatic flush;
      clr <= 8'hFF;
      @(posedge clk);
      clr <= 8'h00;
      tick(3);
   endtask : flush

   task automatic test_regs;
      `CHK("periph after reset", 14'h3FFF, pen)
      `CHK("cpu clock", 1'b1, cpu_en)
      apb(1'b0, standby_pkg::ADDR_CFG, 32'h0);
      `CHK("cfg reset", {21'h0, standby_pkg::CFG_RESET}, rd)
      apb(1'b0, 8'h3C, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      $display("test regs done");
   endtask : test_regs

   // Every row of the wake decision table, masked row last.
   task automatic test_halt;
      for (int i = 0; i < 6; i++) begin
         c = tbl[i];
         mask <= {7'h7F, c[5]};
         prio <= {7'h00, c[4]};
         ie <= c[3];
         in_service_priority_flag <= c[2];
         pulse_instr(1'b0);
         tick(3);
         `CHK("halt clock", 1'b0, cpu_en)
         set_raise(8'h01);
         wait_pulse(10);
         if (c[1:0] == 2'h0) begin
            `CHK("masked held", 1'b0, wpulse)
            mask <= 8'hFE;
            wait_pulse(10);
            `CHK("unmask pulse", 1'b1, wpulse)
            `CHK("unmask wake", 2'h2, wact)
         end else begin
            `CHK("halt wake", 1'b1, wpulse)
            `CHK("halt action", c[1:0], wact)
         end
         flush();
      end
      $display("test halt done");
   endtask : test_halt

   task automatic test_stop(input logic [31:0] cfg, input logic [13:0] exp, input logic use_nmi,
      input logic en, input logic [1:0] act);
      apb(1'b1, standby_pkg::ADDR_CFG, cfg);
      apb(1'b0, standby_pkg::ADDR_CFG, 32'h0);
      `CHK("cfg readback", cfg, rd)
      mask <= 8'hFE;
      prio <= 8'h00;
      ie <= en;
      if (use_nmi) apb(1'b1, standby_pkg::ADDR_CTRL, 32'h1); else pulse_instr(1'b1);
      tick(3);
      `CHK("port hold", 1'b1, hold)
      `CHK("stop clock", 1'b0, cpu_en)
      `CHK("stop periph", exp, pen)
      apb(1'b0, standby_pkg::ADDR_STATUS, 32'h0);
      `CHK("stop status", {28'h0, standby_pkg::WAKE_NONE, standby_pkg::ST_STOP}, rd)
      set_raise(8'h02);
      tick(4);
      `CHK("masked source", 1'b1, hold)
      if (use_nmi) nmi <= 1'b1; else set_raise(8'h01);
      wait_pulse(60);
      nmi <= 1'b0;
      `CHK("stop wake", 1'b1, wpulse)
      `CHK("stop action", act, wact)
      `CHK("settle wait", 1'b1, n >= 16)
      flush();
      `CHK("hold released", 1'b0, hold)
      $display("test stop done");
   endtask : test_stop

   task automatic test_pending;
      apb(1'b1, standby_pkg::ADDR_CFG, 32'h400);
      ie <= 1'b0;
      set_raise(8'h01);
      tick(2);
      pulse_instr(1'b1);
      wait_pulse(60);
      `CHK("pending wake", 1'b1, wpulse)
      `CHK("pending action", 2'h1, wact)
      `CHK("pending settle", 1'b1, n >= 15)
      flush();
      $display("test pending done");
   endtask : test_pending

   task automatic test_reset(input logic in_stop);
      pulse_instr(in_stop);
      tick(3);
      ext_n <= 1'b0;
      tick(5);
      `CHK("core reset", 1'b1, creset)
      ext_n <= 1'b1;
      n = 0;
      while (creset === 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK("reset action", 2'h3, wact)
      `CHK("reset length", in_stop, n >= 8)
      tick(3);
      `CHK("running again", 1'b1, cpu_en)
      $display("test reset done");
   endtask : test_reset

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   // A hang counts as a mismatch; the full run needs only a few hundred cycles.
   initial begin
      tick(20000);
      n_fail++;
      report_and_stop();
   end

   initial begin
      {rst_n, halt, stop, nmi, ie, in_service_priority_flag, psel, penable, pwrite} = '0;
      ext_n = 1'b1;
      {paddr, mask, prio, raise, clr} = '0;
      pwdata = 32'h0;
      n_fail = 0;
      total_checks = 0;
      tick(6);
      rst_n <= 1'b1;
      tick(3);
      test_regs();
      test_halt();
      test_stop(32'h6E8, 14'h00BF, 1'b0, 1'b0, 2'h1);
      test_stop(32'h150, 14'h0045, 1'b0, 1'b1, 2'h2);
      test_stop(32'h6E8, 14'h00BF, 1'b1, 1'b0, 2'h2);
      test_pending();
      test_reset(1'b0);
      test_reset(1'b1);
      report_and_stop();
   end
endmodule : tb
